// ==== hdl/scsc_pkg.sv ====
// Purpose: shared constants for the clock switchover control block
// Assumes: ref_clk is the oscillator-derived system clock at 20 MHz
// Notes:   one 8-bit control register in the special-function space
package scsc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [7:0] CSC_ADDR      = 8'h80;
  localparam logic [7:0] CSC_RESET     = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int unsigned METER_SEL_BIT = 7;
  localparam int unsigned QPLL_BIT      = 6;
  localparam int unsigned QSLEEP_BIT    = 5;
  localparam int unsigned METER_STOP_BIT = 4;
  localparam int unsigned DISP_STOP_BIT = 3;
  localparam int unsigned SLEEP_HI_BIT  = 2;
  localparam int unsigned SLEEP_LO_BIT  = 1;
  localparam int unsigned PROC_SEL_BIT  = 0;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ   = 20000000;
  localparam int unsigned OSC_FREQ_HZ   = 32768;
  // longest wait: one oscillator period, rounded down
  localparam int unsigned OSC_TICK_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int unsigned OSC_CNT_W     = 10;
  localparam logic [OSC_CNT_W-1:0] OSC_TICK_LAST =
    OSC_CNT_W'(OSC_TICK_CYCLES - 1);

  // ------------------------------------------------------------------
  // power state
  // ------------------------------------------------------------------
  typedef enum logic
  {
    PS_RUN   = 1'b0,
    PS_SLEEP = 1'b1
  } scsc_power_e;

endpackage : scsc_pkg

// ==== hdl/scsc_switch_if.sv ====
// Purpose: request and status of one clock domain source switch
// Assumes: single clock domain
// Notes:   req high asks for the pll, in_use shows the live source
`timescale 1ns/1ps
`default_nettype none
interface scsc_switch_if;
  logic req;
  logic tick;
  logic in_use;
  modport ctrl (output req, output tick, input in_use);
  modport sw   (input req, input tick, output in_use);
endinterface : scsc_switch_if
`default_nettype wire

// ==== hdl/scsc_osc_tick.sv ====
// Purpose: one-cycle enable at the oscillator rate
// Assumes: ref_clk at CLK_FREQ_HZ
// Notes:   period is OSC_TICK_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module scsc_osc_tick
  import scsc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // enable
  output logic      tick
);

  logic [OSC_CNT_W-1:0] cnt_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else if (cnt_ff == OSC_TICK_LAST)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + OSC_CNT_W'(1);
  end

  assign tick = (cnt_ff == OSC_TICK_LAST);

endmodule : scsc_osc_tick
`default_nettype wire

// ==== hdl/scsc_src_switch.sv ====
// Purpose: source switch of one clock domain
// Assumes: tick is the oscillator-rate enable
// Notes:   moving to the pll is immediate, back to osc waits a tick
`timescale 1ns/1ps
`default_nettype none
module scsc_src_switch
  import scsc_pkg::*;
(
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  // switch control
  scsc_switch_if.sw   sw
);

  logic in_use_ff;

  // leaving the pll waits for an osc edge so no runt pulse reaches logic
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      in_use_ff <= 1'b0;
    else if (sw.req)
      in_use_ff <= 1'b1;
    else if (sw.tick)
      in_use_ff <= 1'b0;
  end

  assign sw.in_use = in_use_ff;

endmodule : scsc_src_switch
`default_nettype wire

// ==== hdl/scsc_top.sv ====
// Purpose: clock switchover control register and its clock gating
// Assumes: sfr strobes are one-cycle pulses synchronous to ref_clk
// Notes:   reads answer one cycle after the read strobe
//
// Operation
// - select bits choose osc or pll, read live
// - quick pll write ignored while quick sleep set
// - quick pll starts pll, processor moves at once
// - quick pll locks selection; clearing keeps it
// - quick sleep forces osc, pll off, clock stopped
// - quick sleep enters sleep when power-up flag low
// - quick sleep with sleep code 00 never sleeps when power-up flag high
// - display stop only with both domains on pll
// - sleep codes 11, 01 stop clocks, sleep
// - sleep code 10 stops clocks, sleep too
// - wake without reset leaves sleep, no reset
// - wake without reset keeps all other state
// - wake clears sleep field and quick bits
// - metering stop works only on osc source
// - return to osc within one osc cycle
`timescale 1ns/1ps
`default_nettype none
module scsc_top
  import scsc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // special-function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // system status and wake
  input  wire logic       power_up_status,
  input  wire logic       wake_without_reset,
  input  wire logic       wake_event,
  // clock control outputs
  output logic            proc_pll_sel,
  output logic            meter_pll_sel,
  output logic            pll_quick_enable,
  output logic            processor_clock_en,
  output logic            metering_clock_en,
  output logic            display_clock_en,
  output logic            companion_clock_en,
  // power control outputs
  output logic            sleep_active,
  output logic            wake_reset_req
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic        meter_sel_ff;
  logic        proc_sel_ff;
  logic        quick_pll_ff;
  logic        quick_sleep_ff;
  logic        meter_stop_ff;
  logic        disp_stop_ff;
  logic [1:0]  sleep_field_ff;
  logic [7:0]  rdata_ff;
  logic        wake_req_ff;
  scsc_power_e power_ff;
  scsc_power_e nxt_power;

  logic        wr_hit;
  logic        rd_hit;
  logic        wake_clear;
  logic        osc_tick;
  logic        qpll_accept;

  scsc_switch_if proc_sw ();
  scsc_switch_if meter_sw ();

  assign wr_hit      = sfr_wr && (sfr_addr == CSC_ADDR);
  assign rd_hit      = sfr_rd && (sfr_addr == CSC_ADDR);
  assign qpll_accept = wr_hit && !quick_sleep_ff;
  assign wake_clear  = (power_ff == PS_SLEEP) && wake_event &&
                       wake_without_reset;

  // ------------------------------------------------------------------
  // source switches
  // ------------------------------------------------------------------
  scsc_osc_tick u_tick
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick    (osc_tick)
  );

  // quick sleep overrides everything and drops the processor to osc
  assign proc_sw.req  = !quick_sleep_ff &&
                        (quick_pll_ff || proc_sel_ff);
  assign proc_sw.tick = osc_tick;
  assign meter_sw.req  = meter_sel_ff;
  assign meter_sw.tick = osc_tick;

  scsc_src_switch u_proc_sw
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sw      (proc_sw.sw)
  );

  scsc_src_switch u_meter_sw
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sw      (meter_sw.sw)
  );

  // ------------------------------------------------------------------
  // register bits
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      meter_sel_ff <= CSC_RESET[METER_SEL_BIT];
    else if (wr_hit)
      meter_sel_ff <= sfr_wdata[METER_SEL_BIT];
  end

  // the lock is judged on the value before the write
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      proc_sel_ff <= CSC_RESET[PROC_SEL_BIT];
    else if (wr_hit && sfr_wdata[QSLEEP_BIT])
      proc_sel_ff <= 1'b0;
    else if (qpll_accept && sfr_wdata[QPLL_BIT])
      proc_sel_ff <= 1'b1;
    else if (wr_hit && !quick_pll_ff)
      proc_sel_ff <= sfr_wdata[PROC_SEL_BIT];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      quick_pll_ff <= CSC_RESET[QPLL_BIT];
    else if (qpll_accept)
      quick_pll_ff <= sfr_wdata[QPLL_BIT];
    else if (wake_clear)
      quick_pll_ff <= 1'b0;
  end

  // a write in the wake cycle wins over the wake clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quick_sleep_ff <= CSC_RESET[QSLEEP_BIT];
      sleep_field_ff <= CSC_RESET[SLEEP_HI_BIT:SLEEP_LO_BIT];
    end
    else if (wr_hit)
    begin
      quick_sleep_ff <= sfr_wdata[QSLEEP_BIT];
      sleep_field_ff <= sfr_wdata[SLEEP_HI_BIT:SLEEP_LO_BIT];
    end
    else if (wake_clear)
    begin
      quick_sleep_ff <= 1'b0;
      sleep_field_ff <= 2'h0;
    end
  end

  // untouched by wake so the gating survives a sleep
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meter_stop_ff <= CSC_RESET[METER_STOP_BIT];
      disp_stop_ff  <= CSC_RESET[DISP_STOP_BIT];
    end
    else if (wr_hit)
    begin
      meter_stop_ff <= sfr_wdata[METER_STOP_BIT];
      disp_stop_ff  <= sfr_wdata[DISP_STOP_BIT];
    end
  end

  // ------------------------------------------------------------------
  // power state
  // ------------------------------------------------------------------
  always_comb
  begin
    nxt_power = power_ff;
    unique case (power_ff)
      PS_RUN:
      begin
        if (wr_hit && (sfr_wdata[SLEEP_HI_BIT:SLEEP_LO_BIT] != 2'h0))
          nxt_power = PS_SLEEP;
        else if (wr_hit && sfr_wdata[QSLEEP_BIT] && !power_up_status)
          nxt_power = PS_SLEEP;
      end
      PS_SLEEP:
      begin
        if (wake_clear)
          nxt_power = PS_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      power_ff <= PS_RUN;
    else
      power_ff <= nxt_power;
  end

  // a wake with reset enabled is handed to the reset logic outside
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_req_ff <= 1'b0;
    else
      wake_req_ff <= (power_ff == PS_SLEEP) && wake_event &&
                     !wake_without_reset;
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= CSC_RESET;
    else if (rd_hit)
      rdata_ff <= {meter_sw.in_use, quick_pll_ff, quick_sleep_ff,
                   meter_stop_ff, disp_stop_ff, sleep_field_ff,
                   proc_sw.in_use};
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign sfr_rdata          = rdata_ff;
  assign proc_pll_sel       = proc_sw.in_use;
  assign meter_pll_sel      = meter_sw.in_use;
  // pll runs at the fixed quick frequency of 3.2768 MHz in this mode
  assign pll_quick_enable   = quick_pll_ff && !quick_sleep_ff;
  assign processor_clock_en = !quick_sleep_ff &&
                              (sleep_field_ff == 2'h0);
  assign companion_clock_en = (sleep_field_ff == 2'h0);
  assign metering_clock_en  = !(meter_stop_ff &&
                                !meter_sw.in_use);
  assign display_clock_en   = !(disp_stop_ff && proc_sw.in_use &&
                                meter_sw.in_use);
  assign sleep_active       = (power_ff == PS_SLEEP);
  assign wake_reset_req     = wake_req_ff;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  localparam int SW_BOUND = 612;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_read_src: assert property (rd_hit |=>
    sfr_rdata[0] == $past(proc_sw.in_use))
    else $error("read does not show processor source");
  chk_qpll_ignored: assert property (wr_hit && quick_sleep_ff &&
    !wake_clear |=> quick_pll_ff == $past(quick_pll_ff))
    else $error("quick pll written during quick sleep");
  chk_qpll_switch: assert property (
    qpll_accept && sfr_wdata[QPLL_BIT] && !sfr_wdata[QSLEEP_BIT]
    |-> ##2 proc_pll_sel)
    else $error("processor not moved to pll");
  chk_lock_hold: assert property (
    quick_pll_ff && wr_hit && !sfr_wdata[QSLEEP_BIT] &&
    !(qpll_accept && sfr_wdata[QPLL_BIT]) |=> $stable(proc_sel_ff))
    else $error("locked selection changed");
  chk_qsleep_stop: assert property (quick_sleep_ff |->
    !processor_clock_en && !pll_quick_enable)
    else $error("quick sleep left processor clock on");
  chk_qsleep_enter: assert property (
    power_ff == PS_RUN && wr_hit && sfr_wdata[QSLEEP_BIT] &&
    !power_up_status |=> sleep_active)
    else $error("quick sleep did not sleep");
  chk_qsleep_block: assert property (
    power_ff == PS_RUN && wr_hit && sfr_wdata[QSLEEP_BIT] &&
    power_up_status && sfr_wdata[2:1] == 2'h0 |=> !sleep_active)
    else $error("quick sleep slept with power-up flag high");
  chk_disp_gate: assert property (!proc_pll_sel || !meter_pll_sel
    |-> display_clock_en)
    else $error("display stopped off pll");
  chk_field_sleep: assert property (
    wr_hit && sfr_wdata[2:1] != 2'h0
    |=> sleep_active && !companion_clock_en && !processor_clock_en)
    else $error("sleep field did not stop clocks");
  chk_wake_clear: assert property (wake_clear && !wr_hit |=>
    !sleep_active && sleep_field_ff == 2'h0 && !quick_pll_ff &&
    !quick_sleep_ff && !wake_reset_req)
    else $error("wake without reset left bits set");
  chk_wake_keep: assert property (wake_clear && !wr_hit |=>
    $stable(meter_stop_ff) && $stable(disp_stop_ff) &&
    $stable(meter_sel_ff))
    else $error("wake disturbed kept state");
  chk_meter_gate: assert property (meter_stop_ff && !meter_pll_sel
    |-> !metering_clock_en)
    else $error("metering clock not stopped");
  chk_osc_return: assert property ($fell(proc_sw.req) |->
    ##[1:SW_BOUND] !proc_pll_sel)
    else $error("return to osc too slow");

  cov_quick_pll: cover property (qpll_accept && sfr_wdata[QPLL_BIT]);
  cov_sleep_wake: cover property (sleep_active ##[1:20] wake_clear);
  cov_wake_reset: cover property (wake_reset_req);
  cov_disp_stop: cover property (!display_clock_en);

endmodule : scsc_top
`default_nettype wire

// ==== testbench/system_clock_switchover_control_tb.sv ====
// Purpose: self-checking bench for the clock switchover control block
// Assumes: ref_clk 20 MHz, register at CSC_ADDR on the sfr port
// Notes:   flags packs eight of the nine clock and power outputs for compares
`timescale 1ns/1ps
`default_nettype none
module system_clock_switchover_control_tb
  import scsc_pkg::*;
  ;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic       ref_clk;
  logic       rst_n;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       power_up_status;
  logic       wake_without_reset;
  logic       wake_event;
  logic       proc_pll_sel;
  logic       meter_pll_sel;
  logic       pll_quick_enable;
  logic       processor_clock_en;
  logic       metering_clock_en;
  logic       display_clock_en;
  logic       companion_clock_en;
  logic       sleep_active;
  logic       wake_reset_req;
  wire  [7:0] flags;
  int         errors;
  int         total_checks;
  int         cycles;
  int         code;

  // [7]proc sel [6]meter sel [5]quick pll [4:1]enables [0]sleep
  assign flags = {proc_pll_sel, meter_pll_sel, pll_quick_enable,
                  processor_clock_en, metering_clock_en, display_clock_en,
                  companion_clock_en, sleep_active};

  scsc_top u_dut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .power_up_status(power_up_status),
    .wake_without_reset(wake_without_reset), .wake_event(wake_event),
    .proc_pll_sel(proc_pll_sel), .meter_pll_sel(meter_pll_sel),
    .pll_quick_enable(pll_quick_enable),
    .processor_clock_en(processor_clock_en),
    .metering_clock_en(metering_clock_en),
    .display_clock_en(display_clock_en),
    .companion_clock_en(companion_clock_en),
    .sleep_active(sleep_active), .wake_reset_req(wake_reset_req)
  );

  // ------------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // two osc waits of ~612 cycles dominate; generous ceiling
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      $display("[ERR] %0t ns: run did not finish", $time);
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wdata <= d;
    sfr_wr    <= 1'b1;
    @(posedge ref_clk);
    sfr_wr    <= 1'b0;
    @(negedge ref_clk);
  endtask : wr

  // rdata is registered, so look one edge after the strobe is taken
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    @(posedge ref_clk);
    sfr_rd   <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(sfr_rdata, exp);
  endtask : rd

  task automatic wake(input logic keep);
    @(posedge ref_clk);
    wake_without_reset <= keep;
    wake_event         <= 1'b1;
    @(posedge ref_clk);
    wake_event         <= 1'b0;
    @(negedge ref_clk);
  endtask : wake

  // return to osc waits for the free-running tick, bounded
  task automatic wait_osc();
    int i;
    for (i = 0; i < 612; i++)
    begin
      if (proc_pll_sel === 1'b0 && meter_pll_sel === 1'b0)
        break;
      @(negedge ref_clk);
    end
  endtask : wait_osc

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial
  begin
    rst_n              = 1'b0;
    sfr_addr           = 8'h00;
    sfr_wr             = 1'b0;
    sfr_rd             = 1'b0;
    sfr_wdata          = 8'h00;
    power_up_status    = 1'b0;
    wake_without_reset = 1'b1;
    wake_event         = 1'b0;
    errors             = 0;
    total_checks       = 0;
    cycles             = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk(flags, 8'h1E);
    rd(CSC_ADDR, CSC_RESET);
    wr(8'h81, 8'hFF);
    rd(CSC_ADDR, 8'h00);
    chk(flags, 8'h1E);
    $display("test reset and unmapped done");
    wr(CSC_ADDR, 8'h40);
    // live source follows the request one cycle later
    @(negedge ref_clk);
    chk(flags, 8'hBE);
    rd(CSC_ADDR, 8'h41);
    wr(CSC_ADDR, 8'h00);
    chk(flags, 8'h9E);
    rd(CSC_ADDR, 8'h01);
    wr(CSC_ADDR, 8'h00);
    wait_osc();
    chk(flags, 8'h1E);
    rd(CSC_ADDR, 8'h00);
    $display("test quick pll and lock done");
    wr(CSC_ADDR, 8'h81);
    @(negedge ref_clk);
    chk(flags, 8'hDE);
    wr(CSC_ADDR, 8'h89);
    chk(flags, 8'hDA);
    rd(CSC_ADDR, 8'h89);
    rd(8'h7F, 8'h89);
    wr(CSC_ADDR, 8'h08);
    wait_osc();
    chk(flags, 8'h1E);
    rd(CSC_ADDR, 8'h08);
    wr(CSC_ADDR, 8'h10);
    chk(flags, 8'h16);
    wr(CSC_ADDR, 8'h00);
    $display("test display and metering stop done");
    // software side: flag low and processor on osc before sleeping
    power_up_status <= 1'b0;
    wr(CSC_ADDR, 8'h20);
    chk(flags & 8'hFD, 8'h0D);
    wr(CSC_ADDR, 8'h60);
    rd(CSC_ADDR, 8'h20);
    wake(1'b1);
    chk(flags, 8'h1E);
    rd(CSC_ADDR, 8'h00);
    power_up_status <= 1'b1;
    wr(CSC_ADDR, 8'h20);
    chk(flags & 8'hFD, 8'h0C);
    wr(CSC_ADDR, 8'h00);
    chk(flags, 8'h1E);
    power_up_status <= 1'b0;
    $display("test quick sleep done");
    for (code = 1; code < 4; code++)
    begin
      wr(CSC_ADDR, 8'h10 | 8'(code << 1));
      chk(flags, 8'h05);
      wake(1'b0);
      chk({7'h00, wake_reset_req}, 8'h01);
      chk(flags, 8'h05);
      @(negedge ref_clk);
      chk({7'h00, wake_reset_req}, 8'h00);
      wake(1'b1);
      chk(flags, 8'h16);
      rd(CSC_ADDR, 8'h10);
      wr(CSC_ADDR, 8'h00);
    end
    $display("test sleep field codes done");
    tally_and_finish();
  end

endmodule : system_clock_switchover_control_tb
`default_nettype wire
